// ==== eep_slave.sv ====
`timescale 1ns/1ps
module eep_slave #(
	parameter bit P_IS_8K     = 1'b0,
	parameter int P_WR_CYCLES = eep_pkg::WR_CYCLES
) (
	input  wire logic i_clk,
	input  wire logic i_rstn,
	input  wire logic i_ce,
	input  wire logic i_scl,
	input  wire logic i_sda,
	input  wire logic i_select_pin_0,
	input  wire logic i_select_pin_1,
	input  wire logic i_select_pin_2,
	input  wire logic i_write_lock,
	output logic      o_sda,
	output logic      o_sda_oen,
	output logic      o_busy
);
	import eep_pkg::*;

	eep_regs_s          s_q;
	eep_regs_s          s_d;
	logic               scl_rise;
	logic               scl_fall;
	logic               start_ev;
	logic               stop_ev;
	logic               mem_we;
	logic [OFS_W-1:0]   prog_idx;
	logic [ADDR_W-1:0]  mem_waddr;
	logic [BYTE_W-1:0]  mem_rdata;

	function automatic logic dev_match(input logic [BYTE_W-1:0] b, input logic [1:0] sel);
		logic hw;
		hw = P_IS_8K ? (b[DEV_SEL2_BIT] == sel[1]) : (b[DEV_SEL2_BIT:DEV_SEL1_BIT] == sel);
		return (b[7:4] == DEV_TYPE_CODE) && hw;
	endfunction

	function automatic logic [ADDR_W-1:0] addr_fix(input logic [ADDR_W-1:0] a);
		return P_IS_8K ? a : {1'b0, a[ADDR_W-2:0]};
	endfunction

	// edges seen on the second and third sync stages only
	assign scl_rise = i_ce && s_q.scl_s2 && !s_q.scl_s3;
	assign scl_fall = i_ce && !s_q.scl_s2 && s_q.scl_s3;
	assign start_ev = i_ce && s_q.scl_s2 && s_q.scl_s3 && !s_q.sda_s2 && s_q.sda_s3;
	assign stop_ev  = i_ce && s_q.scl_s2 && s_q.scl_s3 && s_q.sda_s2 && !s_q.sda_s3;

	assign prog_idx  = s_q.cnt[OFS_W-1:0];
	assign mem_waddr = {s_q.page, prog_idx};
	// lock is rechecked per byte so a late raise still stops the commit
	assign mem_we    = i_ce && (s_q.st == ST_PROG) && (s_q.cnt < CNT_W'(PAGE_BYTES))
	                   && s_q.mask[prog_idx] && !s_q.wp_s2;

	always_comb begin
		s_d = s_q;
		if (i_ce) begin
			s_d.scl_s1 = i_scl;
			s_d.scl_s2 = s_q.scl_s1;
			s_d.scl_s3 = s_q.scl_s2;
			s_d.sda_s1 = i_sda;
			s_d.sda_s2 = s_q.sda_s1;
			s_d.sda_s3 = s_q.sda_s2;
			// select pin 0 is never sampled at all
			s_d.sel_s1 = {i_select_pin_2, i_select_pin_1};
			s_d.sel_s2 = s_q.sel_s1;
			s_d.wp_s1  = i_write_lock;
			s_d.wp_s2  = s_q.wp_s1;
		end
		if (i_ce) begin
			case (s_q.st)
				ST_PROG: begin
					// busy: bus ignored, nothing acknowledged
					s_d.sda_oen = 1'b1;
					s_d.cnt     = s_q.cnt + CNT_W'(1);
					if (s_q.cnt == CNT_W'(P_WR_CYCLES - 1)) begin
						s_d.st   = ST_IDLE;
						s_d.busy = 1'b0;
						s_d.mask = '0;
					end
				end
				default: begin
					if (start_ev) begin
						s_d.st      = ST_DEV;
						s_d.bitcnt  = '0;
						s_d.ack_ph  = 1'b0;
						s_d.sda_oen = 1'b1;
					end else if (stop_ev) begin
						s_d.sda_oen = 1'b1;
						s_d.ack_ph  = 1'b0;
						s_d.st      = ST_IDLE;
						if ((s_q.st == ST_WDATA) && (|s_q.mask) && !s_q.wp_s2) begin
							s_d.st   = ST_PROG;
							s_d.cnt  = '0;
							s_d.busy = 1'b1;
						end
					end else if (s_q.st != ST_IDLE) begin
						if (scl_rise) begin
							if (s_q.ack_ph) begin
								if ((s_q.st == ST_RDATA) && !s_q.first_rd) begin
									s_d.host_ack = !s_q.sda_s2;
									s_d.addr     = addr_fix(s_q.addr + ADDR_W'(1));
								end
							end else begin
								s_d.shift  = (s_q.st == ST_RDATA) ? s_q.shift : {s_q.shift[BYTE_W-2:0], s_q.sda_s2};
								s_d.bitcnt = s_q.bitcnt + BIT_CNT_W'(1);
							end
						end
						if (scl_fall) begin
							if (s_q.ack_ph) begin
								s_d.ack_ph  = 1'b0;
								s_d.bitcnt  = '0;
								s_d.sda_oen = 1'b1;
								if (s_q.st == ST_RDATA) begin
									if (s_q.first_rd || s_q.host_ack) begin
										// reads are never gated by the lock
										s_d.shift    = {mem_rdata[BYTE_W-2:0], 1'b0};
										s_d.sda_oen  = mem_rdata[BYTE_W-1];
										s_d.first_rd = 1'b0;
									end else begin
										s_d.st = ST_IDLE;
									end
								end
							end else if (s_q.bitcnt == BIT_CNT_W'(BYTE_W)) begin
								s_d.ack_ph = 1'b1;
								case (s_q.st)
									ST_DEV: begin
										if (dev_match(s_q.shift, s_q.sel_s2)) begin
											s_d.sda_oen = 1'b0;
											if (s_q.shift[DEV_RW_BIT]) begin
												s_d.st       = ST_RDATA;
												s_d.first_rd = 1'b1;
											end else begin
												s_d.st   = ST_WADDR;
												s_d.mask = '0;
												// top address bits travel in the address word
												s_d.addr[ADDR_W-2] = s_q.shift[DEV_A8_BIT];
												s_d.addr[ADDR_W-1] = P_IS_8K ? s_q.shift[DEV_A9_BIT] : 1'b0;
											end
										end else begin
											s_d.st     = ST_IDLE;
											s_d.ack_ph = 1'b0;
										end
									end
									ST_WADDR: begin
										s_d.sda_oen = 1'b0;
										s_d.addr    = addr_fix({s_q.addr[ADDR_W-1:BYTE_W], s_q.shift});
										s_d.page    = s_d.addr[ADDR_W-1:OFS_W];
										s_d.st      = ST_WDATA;
									end
									ST_WDATA: begin
										// overflow wraps inside the page, older bytes replaced
										s_d.sda_oen                        = 1'b0;
										s_d.pbuf[s_q.addr[OFS_W-1:0]]      = s_q.shift;
										s_d.mask[s_q.addr[OFS_W-1:0]]      = 1'b1;
										s_d.addr[OFS_W-1:0]                = s_q.addr[OFS_W-1:0] + OFS_W'(1);
									end
									default: begin
										// read byte done: release so the host can answer
										s_d.sda_oen = 1'b1;
									end
								endcase
							end else if (s_q.st == ST_RDATA) begin
								s_d.sda_oen = s_q.shift[BYTE_W-1];
								s_d.shift   = {s_q.shift[BYTE_W-2:0], 1'b0};
							end
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			s_q         <= '0;
			s_q.st      <= ST_IDLE;
			s_q.scl_s1  <= RST_BUS_LVL;
			s_q.scl_s2  <= RST_BUS_LVL;
			s_q.scl_s3  <= RST_BUS_LVL;
			s_q.sda_s1  <= RST_BUS_LVL;
			s_q.sda_s2  <= RST_BUS_LVL;
			s_q.sda_s3  <= RST_BUS_LVL;
			s_q.sda_oen <= RST_SDA_OEN;
			s_q.sda_o   <= RST_SDA_O;
		end else begin
			s_q <= s_d;
		end
	end

	eep_array #(
		.P_ADDR_W (ADDR_W),
		.P_DATA_W (BYTE_W)
	) u_array (
		.i_clk   (i_clk),
		.i_ce    (i_ce),
		.i_we    (mem_we),
		.i_waddr (mem_waddr),
		.i_wdata (s_q.pbuf[prog_idx]),
		.i_raddr (s_q.addr),
		.o_rdata (mem_rdata)
	);

	assign o_sda     = s_q.sda_o;
	assign o_sda_oen = s_q.sda_oen;
	assign o_busy    = s_q.busy;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	AST_OPEN_DRAIN: assert property (o_sda == 1'b0)
		else $error("data pin driven high");
	AST_DRIVE_ON_FALL: assert property ($fell(o_sda_oen) |-> $past(scl_fall))
		else $error("data line pulled low away from a clock fall");
	AST_ACK_MATCH: assert property ((scl_fall && s_q.st == ST_DEV && !s_q.ack_ph && s_q.bitcnt == 4'h8
		&& dev_match(s_q.shift, s_q.sel_s2)) |=> (!o_sda_oen && s_q.ack_ph))
		else $error("matching address word not acknowledged");
	AST_NAK_MISMATCH: assert property ((scl_fall && s_q.st == ST_DEV && !s_q.ack_ph && s_q.bitcnt == 4'h8
		&& !dev_match(s_q.shift, s_q.sel_s2)) |=> (o_sda_oen && s_q.st == ST_IDLE))
		else $error("foreign address word acknowledged");
	AST_BUSY_SILENT: assert property (o_busy |-> o_sda_oen)
		else $error("bus driven during programming");
	AST_PROG_BOUND: assert property ((s_q.st == ST_PROG) |-> (s_q.cnt < CNT_W'(P_WR_CYCLES)))
		else $error("programming cycle overran");
	AST_PROG_EXIT: assert property ((i_ce && s_q.st == ST_PROG && s_q.cnt == CNT_W'(P_WR_CYCLES - 1))
		|=> (!o_busy && s_q.st == ST_IDLE))
		else $error("programming did not end on time");
	AST_LOCK_NO_PROG: assert property ((stop_ev && s_q.wp_s2 && s_q.st != ST_PROG) |=> !o_busy)
		else $error("program started while locked");
	AST_WRITE_IN_PAGE: assert property (mem_we |-> (mem_waddr[ADDR_W-1:OFS_W] == s_q.page && !s_q.wp_s2))
		else $error("write outside latched page");
	AST_ONLY_SENT: assert property (mem_we |-> s_q.mask[prog_idx])
		else $error("unsent byte programmed");
	AST_4K_ADDR: assert property (!P_IS_8K |-> (s_q.addr[ADDR_W-1] == 1'b0))
		else $error("4K address exceeds 9 bits");
	AST_START: assert property ((start_ev && s_q.st != ST_PROG) |=> (s_q.st == ST_DEV && s_q.bitcnt == 4'h0))
		else $error("start condition not honoured");

	COV_PROG: cover property ($rose(o_busy));
	COV_READ_SEQ: cover property (scl_fall && s_q.st == ST_RDATA && s_q.ack_ph && s_q.host_ack && !s_q.first_rd);
	COV_RESTART: cover property (start_ev && s_q.st == ST_WDATA);
	COV_LOCKED_STOP: cover property (stop_ev && s_q.st == ST_WDATA && s_q.wp_s2);

endmodule

// ==== eep_pkg.sv ====
package eep_pkg;

	// device type code carried in the top nibble of the address word
	localparam logic [3:0] DEV_TYPE_CODE = 4'ha;

	// field positions inside the device address word
	localparam int DEV_RW_BIT   = 0;
	localparam int DEV_A8_BIT   = 1;
	localparam int DEV_A9_BIT   = 2;
	localparam int DEV_SEL1_BIT = 2;
	localparam int DEV_SEL2_BIT = 3;

	// array geometry
	localparam int ADDR_W     = 10;
	localparam int BYTE_W     = 8;
	localparam int OFS_W      = 4;
	localparam int PAGE_W     = ADDR_W - OFS_W;
	localparam int PAGE_BYTES = 16;
	localparam int BIT_CNT_W  = 4;

	// self-timed programming cycle, longest time converted exactly to system clocks
	localparam int T_WR_MS   = 5;
	localparam int CLK_KHZ   = 40000;
	localparam int WR_CYCLES = T_WR_MS * CLK_KHZ;
	localparam int CNT_W     = 18;

	// reset values of the pin side
	localparam logic RST_SDA_OEN = 1'b1;
	localparam logic RST_SDA_O   = 1'b0;
	localparam logic RST_BUS_LVL = 1'b1;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DEV,
		ST_WADDR,
		ST_WDATA,
		ST_RDATA,
		ST_PROG
	} eep_state_e;

	typedef struct packed {
		logic                                 scl_s1;
		logic                                 scl_s2;
		logic                                 scl_s3;
		logic                                 sda_s1;
		logic                                 sda_s2;
		logic                                 sda_s3;
		logic [1:0]                           sel_s1;
		logic [1:0]                           sel_s2;
		logic                                 wp_s1;
		logic                                 wp_s2;
		eep_state_e                           st;
		logic [BIT_CNT_W-1:0]                 bitcnt;
		logic                                 ack_ph;
		logic                                 first_rd;
		logic                                 host_ack;
		logic [BYTE_W-1:0]                    shift;
		logic [ADDR_W-1:0]                    addr;
		logic [PAGE_W-1:0]                    page;
		logic [PAGE_BYTES-1:0]                mask;
		logic [PAGE_BYTES-1:0][BYTE_W-1:0]    pbuf;
		logic [CNT_W-1:0]                     cnt;
		logic                                 sda_oen;
		logic                                 sda_o;
		logic                                 busy;
	} eep_regs_s;

endpackage

// ==== eep_array.sv ====
`timescale 1ns/1ps
module eep_array #(
	parameter int P_ADDR_W = eep_pkg::ADDR_W,
	parameter int P_DATA_W = eep_pkg::BYTE_W
) (
	input  wire logic                i_clk,
	input  wire logic                i_ce,
	input  wire logic                i_we,
	input  wire logic [P_ADDR_W-1:0] i_waddr,
	input  wire logic [P_DATA_W-1:0] i_wdata,
	input  wire logic [P_ADDR_W-1:0] i_raddr,
	output logic      [P_DATA_W-1:0] o_rdata
);
	import eep_pkg::*;

	// non-volatile contents: deliberately not reset
	logic [P_DATA_W-1:0] mem_q [0:(1<<P_ADDR_W)-1];
	logic [P_DATA_W-1:0] rdata_q;

	always_ff @(posedge i_clk) begin
		if (i_ce) begin
			if (i_we) begin
				mem_q[i_waddr] <= i_wdata;
			end
			rdata_q <= mem_q[i_raddr];
		end
	end

	assign o_rdata = rdata_q;

endmodule

// ==== eep_host_model.sv ====
`timescale 1ns/1ps
module eep_host_model (
	input  wire logic i_clk,
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda_oen
);
	// clock parks high between frames, data released to the pull-up
	initial begin
		o_scl     = 1'b1;
		o_sda_oen = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
	endtask
	// long release before the clock rises: the target may still hold its ack
	task automatic start();
		o_sda_oen <= 1'b1;
		tick(6);
		o_scl <= 1'b1;
		tick(4);
		o_sda_oen <= 1'b0; // falling data with clock high
		tick(4);
		o_scl <= 1'b0;
		tick(1);
	endtask
	task automatic stop();
		o_sda_oen <= 1'b0;
		tick(4);
		o_scl <= 1'b1;
		tick(4);
		o_sda_oen <= 1'b1; // rising data with clock high
		tick(1);
	endtask
	// 8 system clocks a bit; faster than a real host, keeps runs short
	// target logic counts system clocks only, so the rate scales down freely
	task automatic bit_x(input logic b, output logic r);
		o_sda_oen <= b; // data moves only while clock is low
		tick(4); // low and high phases fixed in system clocks
		o_scl <= 1'b1;
		tick(3);
		r = i_sda;
		o_scl <= 1'b0;
		tick(1);
	endtask
	task automatic byte_x(input logic [7:0] d, input logic ack_in, output logic [7:0] r, output logic ack);
		for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
		bit_x(ack_in, ack); // ninth clock acknowledge
	endtask
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
	import eep_pkg::*;
	localparam int WR = 64;
	logic       i_clk, i_rstn, wl, sd4, sd8, oen4, oen8, b4, b8, h_scl, h_oen, sda_w;
	logic [2:0] sel4, sel8;
	int         miscompares, checks_done;
	assign sda_w = h_oen & (oen4 | sd4) & (oen8 | sd8);
	eep_host_model host_u (.i_clk(i_clk), .i_sda(sda_w), .o_scl(h_scl), .o_sda_oen(h_oen));
	eep_slave #(.P_IS_8K(1'b0), .P_WR_CYCLES(WR)) dut_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(1'b1),
		.i_scl(h_scl), .i_sda(sda_w), .i_select_pin_0(sel4[0]), .i_select_pin_1(sel4[1]),
		.i_select_pin_2(sel4[2]), .i_write_lock(wl), .o_sda(sd4), .o_sda_oen(oen4), .o_busy(b4));
	eep_slave #(.P_IS_8K(1'b1), .P_WR_CYCLES(WR)) dut8_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(1'b1),
		.i_scl(h_scl), .i_sda(sda_w), .i_select_pin_0(sel8[0]), .i_select_pin_1(sel8[1]),
		.i_select_pin_2(sel8[2]), .i_write_lock(wl), .o_sda(sd8), .o_sda_oen(oen8), .o_busy(b8));
	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic test_done();
		if (miscompares == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic wr(input logic [7:0] dw, input logic [7:0] wa, input logic [7:0] d[$], input logic ok);
		logic [7:0] r;
		logic       a;
		host_u.start();
		host_u.byte_x(dw, 1'b1, r, a);
		chk("address ack", a, !ok);
		if (ok) begin
			host_u.byte_x(wa, 1'b1, r, a);
			foreach (d[i]) begin
				host_u.byte_x(d[i], 1'b1, r, a);
				chk("data ack", a, 1'b0);
			end
		end
		host_u.stop();
	endtask
	// busy is counted over a fixed window that also gives the bus its free time
	task automatic prog(input int exp);
		int n;
		n = 0;
		repeat (WR + 40) begin
			@(negedge i_clk);
			if ((b4 | b8) === 1'b1)
				n++;
		end
		chk("busy cycles", n[15:0], exp[15:0]);
	endtask
	task automatic rd(input logic [7:0] dw, input logic [7:0] wa, input int n, output logic [7:0] q[$]);
		logic [7:0] r;
		logic       a;
		q = {};
		host_u.start();
		host_u.byte_x(dw, 1'b1, r, a);
		host_u.byte_x(wa, 1'b1, r, a);
		host_u.start();
		host_u.byte_x(dw | 8'h01, 1'b1, r, a);
		chk("read ack", a, 1'b0);
		for (int i = 0; i < n; i++) begin
			host_u.byte_x(8'hff, (i == n - 1), r, a);
			q.push_back(r);
		end
		host_u.stop();
	endtask
	task automatic t_reset();
		chk("oen", {oen4, oen8}, 2'b11);
		chk("pin out", {sd4, sd8}, 2'b00);
		chk("busy", {b4, b8}, 2'b00);
	endtask
	task automatic t_page();
		logic [7:0] d[$];
		logic [7:0] q[$];
		for (int k = 0; k < 16; k++)
			d.push_back(8'(k) ^ 8'h3c);
		wr(8'ha6, 8'hf0, d, 1'b1);
		prog(WR);
		wr(8'ha6, 8'hf5, {8'hc0, 8'hc1, 8'hc2}, 1'b1);
		prog(WR);
		wr(8'ha4, 8'hf5, {8'h99}, 1'b1);
		prog(WR);
		rd(8'ha6, 8'hf0, 16, q);
		for (int k = 0; k < 16; k++)
			chk("page byte", q[k], (k >= 5 && k <= 7) ? 8'hbb + 8'(k) : d[k]);
		rd(8'ha4, 8'hf5, 1, q);
		chk("lower half", q[0], 8'h99);
	endtask
	task automatic t_refuse();
		wr(8'ha0, 8'h00, {8'h55}, 1'b0);
		wr(8'hb4, 8'h00, {8'h55}, 1'b0);
		prog(0);
	endtask
	task automatic t_lock();
		logic [7:0] q[$];
		wl <= 1'b1;
		wr(8'ha6, 8'hf0, {8'h00, 8'h00}, 1'b1);
		prog(0);
		rd(8'ha6, 8'hf0, 2, q);
		chk("locked byte", {q[0], q[1]}, 16'h3c3d);
		wl <= 1'b0;
	endtask
	task automatic t_8k();
		logic [7:0] q[$];
		wr(8'hae, 8'hfe, {8'h11, 8'h22}, 1'b1);
		prog(WR);
		rd(8'hae, 8'hfe, 2, q);
		chk("8k bytes", {q[0], q[1]}, 16'h1122);
		rd(8'ha6, 8'hfe, 1, q);
		chk("4k untouched", q[0], 8'h0e ^ 8'h3c);
	endtask
	// pin 0 of the 4K part and pins 0 and 1 of the 8K part held high: must not matter
	initial begin
		miscompares = 0;
		checks_done = 0;
		i_rstn = 1'b0;
		wl = 1'b0;
		sel4 = 3'b011;
		sel8 = 3'b111;
		repeat (8) @(posedge i_clk);
		i_rstn <= 1'b1;
		repeat (4) @(posedge i_clk);
		t_reset();
		t_page();
		t_refuse();
		t_lock();
		t_8k();
		test_done();
	end
	initial begin
		#1000000;
		miscompares++;
		test_done();
	end
endmodule
